// file: hw/irq_prio.sv
// Priority coder for the interrupt identification field.
// Assumes pending bits already carry their enables.
`timescale 1ns/1ps
module irq_prio
    import uart_ctrl_pkg::*;
(
    irq_sel_if.coder sel // Pending in, code out
);
    // Line errors first, modem changes last
    always_comb begin
        sel.none = 1'b0;
        sel.code = ID_MODEM;
        if (sel.pending[SRC_LINE]) begin
            sel.code = ID_LINE;
        end else if (sel.pending[SRC_RX]) begin
            sel.code = ID_RX_AVAIL;
        end else if (sel.pending[SRC_TMO]) begin
            sel.code = ID_TIMEOUT;
        end else if (sel.pending[SRC_TX]) begin
            sel.code = ID_TX_EMPTY;
        end else if (sel.pending[SRC_MODEM]) begin
            sel.code = ID_MODEM;
        end else begin
            sel.none = 1'b1;
        end
    end
endmodule : irq_prio

// file: hw/irq_sel_if.sv
// Carries pending sources to the priority coder and the code back.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface irq_sel_if;
    logic [4:0] pending;
    logic [2:0] code;
    logic none;
    modport regs (output pending, input code, input none);
    modport coder (input pending, output code, output none);
endinterface : irq_sel_if

// file: hw/uart_ctrl_pkg.sv
// Constants for the control side of one UART channel.
// Assumes a 32-bit APB master with one register per word.
package uart_ctrl_pkg;
    // Register indices; byte address is four times the index
    localparam logic [2:0] IDX_DATA = 3'h0;
    localparam logic [2:0] IDX_IRQ_EN = 3'h1;
    localparam logic [2:0] IDX_ID_FIFO = 3'h2;
    localparam logic [2:0] IDX_LFC = 3'h3;
    localparam logic [2:0] IDX_MCTL = 3'h4;
    localparam logic [2:0] IDX_LAST = 3'h4;
    // Field positions
    localparam int B_ADDR_ONLY = 4;
    localparam int B_FIFO_EN = 0;
    localparam int B_RX_FLUSH = 1;
    localparam int B_TX_FLUSH = 2;
    localparam int B_TRIG_LO = 6;
    localparam int B_DIV_SEL = 7;
    localparam int B_BREAK = 6;
    localparam int B_EXTRA_STOP = 2;
    localparam int B_LOOP = 4;
    localparam int B_IRQ_GATE = 3;
    localparam int B_GENERAL_OUTPUT_BIT = 2;
    localparam int B_RTS = 1;
    localparam int B_DTR = 0;
    // Reset values
    localparam logic [4:0] IRQ_EN_RST = 5'h00;
    localparam logic [7:0] LFC_RST = 8'h00;
    localparam logic [4:0] MCTL_RST = 5'h00;
    localparam logic [7:0] DLL_RST = 8'h01;
    localparam logic [7:0] DLM_RST = 8'h00;
    // Interrupt source codes
    localparam logic [2:0] ID_MODEM = 3'h0;
    localparam logic [2:0] ID_TX_EMPTY = 3'h1;
    localparam logic [2:0] ID_RX_AVAIL = 3'h2;
    localparam logic [2:0] ID_TIMEOUT = 3'h6;
    localparam logic [2:0] ID_LINE = 3'h3;
    // Source order in the pending vector
    typedef enum logic [2:0] {SRC_MODEM, SRC_TX, SRC_RX, SRC_TMO, SRC_LINE} src_t;
    // Parity modes presented to the transmitter and receiver
    typedef enum logic [2:0] {PAR_NONE, PAR_ODD, PAR_EVEN, PAR_ONE, PAR_ZERO} parity_t;
endpackage : uart_ctrl_pkg

// file: hw/uart_ctrl_regs.sv
// Control registers of one UART channel behind an APB slave.
// Assumes the data path, line status and modem status live in
// neighbouring blocks on the same clock; modem and serial pins are async.
`timescale 1ns/1ps
module uart_ctrl_regs
    import uart_ctrl_pkg::*;
(
    input wire logic clk, // 100 MHz clock
    input wire logic reset_n, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [31:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB byte strobes
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error for unmapped index
    input wire logic [7:0] rx_data, // Received byte at the head
    output logic [7:0] tx_data, // Byte to transmit
    output logic tx_write, // Pulse: tx_data valid
    output logic rx_read, // Pulse: receive byte consumed
    input wire logic nine_bit_mode, // Nine-bit mode enabled
    input wire logic addr_rcvd, // Pulse: address byte received
    input wire logic rx_avail, // Receive data at threshold
    input wire logic tx_empty, // Transmit holding empty
    input wire logic line_err, // Receive line error present
    input wire logic char_timeout, // Character timeout present
    input wire logic modem_change, // Modem status delta present
    output logic address_only_receive, // Receiver takes addresses only
    output logic [4:0] rx_threshold, // Receive trigger level in bytes
    output logic fifo_enable, // Both FIFOs enabled
    output logic tx_queue_flush, // Pulse: flush transmit FIFO
    output logic rx_queue_flush, // Pulse: flush receive FIFO
    output logic [15:0] divisor, // Baud divisor
    output logic [1:0] char_length_sel, // Word length code
    output logic extra_stop_sel, // 1.5 or 2 stop bits
    output parity_t parity_mode, // Parity mode
    output logic [3:0] modem_lines, // DCD, RI, DSR, CTS, active high
    input wire logic tx_serial, // Serial stream from transmitter
    output logic rx_serial, // Serial stream to receiver
    input wire logic sin_pin, // Serial input pin
    output logic sout_pin, // Serial output pin
    input wire logic cts_n, // Clear-to-send pin
    input wire logic dsr_n, // Data-set-ready pin
    input wire logic ri_n, // Ring pin
    input wire logic dcd_n, // Carrier-detect pin
    output logic rts_n, // Request-to-send pin
    output logic dtr_n, // Terminal-ready pin
    output logic irq // Interrupt request, active high
);
    // All state of the block
    typedef struct packed {
        logic [4:0] irq_en;
        logic [7:0] lfc;
        logic [4:0] mctl;
        logic fifo_en;
        logic [1:0] trig;
        logic [7:0] dll;
        logic [7:0] dlm;
        logic tx_flush;
        logic rx_flush;
        logic tx_wr;
        logic rx_rd;
        logic [7:0] tx_byte;
        logic [7:0] rdata;
        logic err;
        logic addr_hit;
        logic [4:0] sync1;
        logic [4:0] sync2;
    } state_t;

    state_t st_q;
    state_t st_d;
    irq_sel_if sel();
    logic [2:0] idx;
    logic setup;
    logic wr_en;
    logic loop;
    logic addr_only_eff;
    logic [7:0] irq_en_rd;
    logic [7:0] iir_rd;

    // Trigger code to byte count
    function automatic logic [4:0] trig_bytes(input logic [1:0] t);
        unique case (t)
            2'h0: trig_bytes = 5'h01;
            2'h1: trig_bytes = 5'h04;
            2'h2: trig_bytes = 5'h08;
            2'h3: trig_bytes = 5'h0E;
        endcase
    endfunction : trig_bytes

    // Parity bits 5-3 to mode
    function automatic parity_t parity_of(input logic [2:0] p);
        parity_t m;
        m = PAR_NONE;
        if (p[0]) begin
            unique case (p[2:1])
                2'h0: m = PAR_ODD;
                2'h1: m = PAR_EVEN;
                2'h2: m = PAR_ONE;
                2'h3: m = PAR_ZERO;
            endcase
        end
        return m;
    endfunction : parity_of

    irq_prio u_prio (
        .sel(sel.coder)
    );

    // Bus decode; upper address bits beyond the index are ignored
    assign idx = paddr[4:2];
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite;
    assign loop = st_q.mctl[B_LOOP];
    assign addr_only_eff = st_q.irq_en[B_ADDR_ONLY] && nine_bit_mode;
    assign irq_en_rd = {3'h0, addr_only_eff, st_q.irq_en[3:0]};
    assign iir_rd = {st_q.fifo_en, st_q.fifo_en, 2'h0, sel.code, sel.none};

    // Sources gated by their enables; the gate bit acts on the pin only
    always_comb begin
        sel.pending = '0;
        sel.pending[SRC_MODEM] = modem_change && st_q.irq_en[3];
        sel.pending[SRC_LINE] = line_err && st_q.irq_en[2];
        sel.pending[SRC_TX] = tx_empty && st_q.irq_en[1];
        sel.pending[SRC_RX] = (rx_avail || st_q.addr_hit) && st_q.irq_en[0];
        sel.pending[SRC_TMO] = char_timeout && st_q.irq_en[0];
    end

    // Next-state logic for registers, pulses and synchronisers
    always_comb begin
        st_d = st_q;
        st_d.tx_flush = 1'b0;
        st_d.rx_flush = 1'b0;
        st_d.tx_wr = 1'b0;
        st_d.rx_rd = 1'b0;
        st_d.sync1 = {sin_pin, dcd_n, ri_n, dsr_n, cts_n};
        st_d.sync2 = st_q.sync1;
        // Read data and error are captured in setup so they come from flops
        if (setup) begin
            st_d.err = (idx > IDX_LAST) ? 1'b1 : 1'b0;
            st_d.rdata = 8'h00;
            unique case (idx)
                IDX_DATA: st_d.rdata = st_q.lfc[B_DIV_SEL] ? st_q.dll : rx_data;
                IDX_IRQ_EN: st_d.rdata = st_q.lfc[B_DIV_SEL] ? st_q.dlm : irq_en_rd;
                IDX_ID_FIFO: st_d.rdata = iir_rd;
                IDX_LFC: st_d.rdata = st_q.lfc;
                IDX_MCTL: st_d.rdata = {3'h0, st_q.mctl};
                default: st_d.rdata = 8'h00;
            endcase
        end
        // Reading received data consumes it
        if (psel && penable && !pwrite && idx == IDX_DATA && !st_q.lfc[B_DIV_SEL]) begin
            st_d.rx_rd = 1'b1;
        end
        // Address hits stay pending until the byte is read; a new hit wins
        if (rx_read) begin
            st_d.addr_hit = 1'b0;
        end
        if (addr_rcvd && addr_only_eff) begin
            st_d.addr_hit = 1'b1;
        end
        // Writes take effect at the access edge, low lane only
        if (wr_en && pstrb[0]) begin
            unique case (idx)
                IDX_DATA: begin
                    if (st_q.lfc[B_DIV_SEL]) begin
                        st_d.dll = pwdata[7:0];
                    end else begin
                        st_d.tx_byte = pwdata[7:0];
                        st_d.tx_wr = 1'b1;
                    end
                end
                IDX_IRQ_EN: begin
                    if (st_q.lfc[B_DIV_SEL]) begin
                        st_d.dlm = pwdata[7:0];
                    end else begin
                        st_d.irq_en = pwdata[4:0];
                    end
                end
                IDX_ID_FIFO: begin
                    st_d.trig = pwdata[B_TRIG_LO+1:B_TRIG_LO];
                    st_d.fifo_en = pwdata[B_FIFO_EN];
                    st_d.tx_flush = pwdata[B_TX_FLUSH];
                    st_d.rx_flush = pwdata[B_RX_FLUSH];
                end
                IDX_LFC: st_d.lfc = pwdata[7:0];
                IDX_MCTL: st_d.mctl = pwdata[4:0];
                default: st_d.err = 1'b1;
            endcase
        end
    end

    // State register; constants only under reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= '{irq_en: IRQ_EN_RST, lfc: LFC_RST, mctl: MCTL_RST, fifo_en: 1'b0, trig: 2'h0,
                      dll: DLL_RST, dlm: DLM_RST, tx_flush: 1'b0, rx_flush: 1'b0,
                      tx_wr: 1'b0, rx_rd: 1'b0, tx_byte: 8'h00, rdata: 8'h00, err: 1'b0,
                      addr_hit: 1'b0, sync1: 5'h1F, sync2: 5'h1F};
        end else begin
            st_q <= st_d;
        end
    end

    // Zero-wait slave: every access phase completes at once
    assign pready = 1'b1;
    assign pslverr = psel && penable && st_q.err;
    assign prdata = {24'h000000, st_q.rdata};

    // Configuration towards the data path
    assign tx_data = st_q.tx_byte;
    assign tx_write = st_q.tx_wr;
    assign rx_read = st_q.rx_rd;
    assign address_only_receive = addr_only_eff;
    assign rx_threshold = trig_bytes(st_q.trig);
    assign fifo_enable = st_q.fifo_en;
    assign tx_queue_flush = st_q.tx_flush;
    assign rx_queue_flush = st_q.rx_flush;
    assign divisor = {st_q.dlm, st_q.dll};
    assign char_length_sel = st_q.lfc[1:0];
    assign extra_stop_sel = st_q.lfc[B_EXTRA_STOP];
    assign parity_mode = parity_of(st_q.lfc[5:3]);

    // Loopback keeps the pins quiet, except that break still drives sout_pin low, and feeds the receiver internally
    assign sout_pin = st_q.lfc[B_BREAK] ? 1'b0 : (loop ? 1'b1 : tx_serial);
    assign rx_serial = loop ? tx_serial : st_q.sync2[4];
    assign rts_n = loop ? 1'b1 : !st_q.mctl[B_RTS];
    assign dtr_n = loop ? 1'b1 : !st_q.mctl[B_DTR];

    // Modem inputs, or the control bits themselves in loopback
    assign modem_lines = loop
        ? {st_q.mctl[B_IRQ_GATE], st_q.mctl[B_GENERAL_OUTPUT_BIT], st_q.mctl[B_DTR], st_q.mctl[B_RTS]}
        : ~st_q.sync2[3:0];

    // Interrupt pin: any pending source, only while the gate bit is set
    assign irq = st_q.mctl[B_IRQ_GATE] && !sel.none;

    // Checks on the block's own outputs and internal state
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    logic wr_irq_en;
    logic wr_mctl;
    logic wr_fcr;
    assign wr_irq_en = wr_en && pstrb[0] && idx == IDX_IRQ_EN;
    assign wr_mctl = wr_en && pstrb[0] && idx == IDX_MCTL;
    assign wr_fcr = wr_en && pstrb[0] && idx == IDX_ID_FIFO;

    a_enables_locked: assert property (wr_irq_en && st_q.lfc[B_DIV_SEL] |=> $stable(st_q.irq_en))
        else $error("enable bits changed with divisor select set");
    a_dlm_write: assert property (wr_irq_en && st_q.lfc[B_DIV_SEL] |=> divisor[15:8] == $past(pwdata[7:0]))
        else $error("divisor high byte not written");
    a_tx_flush: assert property (wr_fcr && pwdata[B_TX_FLUSH] |=> tx_queue_flush ##1 !tx_queue_flush)
        else $error("transmit flush not a single pulse");
    a_rx_flush: assert property (wr_fcr && pwdata[B_RX_FLUSH] |=> rx_queue_flush ##1 !rx_queue_flush)
        else $error("receive flush not a single pulse");
    a_rts_drive: assert property (wr_mctl && !pwdata[B_LOOP] |=> rts_n == !$past(pwdata[B_RTS]))
        else $error("request-to-send pin not inverted");
    a_dtr_drive: assert property (wr_mctl && !pwdata[B_LOOP] |=> dtr_n == !$past(pwdata[B_DTR]))
        else $error("terminal-ready pin not inverted");
    a_irq_gate: assert property (!st_q.mctl[B_IRQ_GATE] |-> !irq)
        else $error("interrupt leaked past gate");
    a_break_line: assert property (st_q.lfc[B_BREAK] |-> !sout_pin)
        else $error("break not forced");
    a_addr_only_off: assert property (!nine_bit_mode |-> !address_only_receive)
        else $error("address-only active outside nine-bit mode");
    a_loop_return: assert property (loop |-> rx_serial == tx_serial && modem_lines[2] == st_q.mctl[B_GENERAL_OUTPUT_BIT])
        else $error("loopback path broken");
    a_line_first: assert property (line_err && st_q.irq_en[2] |-> sel.code == ID_LINE && !sel.none)
        else $error("line status not top priority");

    c_div_write: cover property (wr_irq_en && st_q.lfc[B_DIV_SEL]);
    c_loop_irq: cover property (loop && irq);
    c_addr_hit: cover property (addr_rcvd && addr_only_eff ##1 irq);
endmodule : uart_ctrl_regs

// file: tb/modem_model.sv
// Remote modem model facing the channel's modem and serial pins.
// Assumes the channel clock; handshake answers come quickly or slowly.
`timescale 1ns/1ps
module modem_model (
    input wire logic clk, // Channel clock
    input wire logic slow, // Long handshake delay
    input wire logic ring, // Ring request from the bench
    input wire logic rts_n, // Request-to-send from channel
    input wire logic dtr_n, // Terminal-ready from channel
    input wire logic sout_pin, // Serial out from channel
    output logic cts_n, // Clear-to-send
    output logic dsr_n, // Data-set-ready
    output logic ri_n, // Ring
    output logic dcd_n, // Carrier detect
    output logic sin_pin // Serial in
);
    logic [3:0] rts_q = 4'hF;
    logic [3:0] dtr_q = 4'hF;
    // Answers lag the requests, so the channel cannot rely on instant replies
    always @(posedge clk) begin
        rts_q <= {rts_q[2:0], rts_n};
        dtr_q <= {dtr_q[2:0], dtr_n};
    end
    assign cts_n = slow ? rts_q[3] : rts_q[0];
    assign dsr_n = slow ? dtr_q[3] : dtr_q[0];
    assign dcd_n = dsr_n; // Carrier only once the set is ready
    assign ri_n = !ring;
    assign sin_pin = sout_pin; // Echo plug at the far end
endmodule : modem_model

// file: tb/testbench.sv
// Self-checking bench for the UART control registers over APB.
// Assumes the register map in uart_ctrl_pkg and a modem model on the pins.
`timescale 1ns/1ps
module testbench;
    import uart_ctrl_pkg::*;
    typedef struct packed {logic [7:0] fmt; logic [2:0] par; logic [1:0] len; logic stop;} lcr_row_t;
    logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, tx_write, rx_read, nine_bit_mode = 1'b0, addr_rcvd = 1'b0;
    logic [7:0] rx_data = 8'hA5, tx_data;
    logic [4:0] src_v = 5'h00; // Timeout, modem, line, tx, rx
    logic address_only_receive, fifo_enable, tx_queue_flush, rx_queue_flush, extra_stop_sel;
    logic [4:0] rx_threshold;
    logic [15:0] divisor;
    logic [1:0] char_length_sel;
    parity_t parity_mode;
    logic [3:0] modem_lines;
    logic tx_ser = 1'b1, rx_serial, sin_pin, sout_pin, cts_n, dsr_n, ri_n, dcd_n, rts_n, dtr_n, irq;
    logic slow = 1'b0, ring = 1'b0;
    int num_errors = 0, checked = 0, n_txf = 0, n_rxf = 0, n_rd = 0, n_wr = 0;
    lcr_row_t rows [6] = '{'{8'h00, PAR_NONE, 2'h0, 1'b0}, '{8'h09, PAR_ODD, 2'h1, 1'b0},
        '{8'h1A, PAR_EVEN, 2'h2, 1'b0}, '{8'h2F, PAR_ONE, 2'h3, 1'b1}, '{8'h7C, PAR_ZERO, 2'h0, 1'b1},
        '{8'h14, PAR_NONE, 2'h0, 1'b1}};
    logic [2:0] codes [4] = '{3'h2, 3'h1, 3'h3, 3'h0};
    logic [4:0] thr [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};

    uart_ctrl_regs dut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata,
        .pready, .pslverr, .rx_data, .tx_data, .tx_write, .rx_read, .nine_bit_mode, .addr_rcvd,
        .rx_avail(src_v[0]), .tx_empty(src_v[1]), .line_err(src_v[2]), .modem_change(src_v[3]),
        .char_timeout(src_v[4]), .address_only_receive, .rx_threshold, .fifo_enable, .tx_queue_flush,
        .rx_queue_flush, .divisor, .char_length_sel, .extra_stop_sel, .parity_mode, .modem_lines,
        .tx_serial(tx_ser), .rx_serial, .sin_pin, .sout_pin, .cts_n, .dsr_n, .ri_n, .dcd_n, .rts_n,
        .dtr_n, .irq);
    modem_model partner (.clk, .slow, .ring, .rts_n, .dtr_n, .sout_pin, .cts_n, .dsr_n, .ri_n, .dcd_n,
        .sin_pin);

    always #5 clk = ~clk;
    // Pulse counters, so single-cycle strobes are never missed by sampling
    always @(posedge clk) begin
        n_txf += int'(tx_queue_flush === 1'b1);
        n_rxf += int'(rx_queue_flush === 1'b1);
        n_rd += int'(rx_read === 1'b1);
        n_wr += int'(tx_write === 1'b1);
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [2:0] idx, input logic [7:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {27'h0, idx, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) num_errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Modem inputs pass synchronisers, so allow a bounded settle
    task automatic wait_lines(input logic [3:0] exp);
        int n;
        n = 0;
        while (modem_lines !== exp && n < 12) begin
            @(posedge clk);
            n++;
        end
        chk("modem_lines", modem_lines, exp);
    endtask : wait_lines

    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        chk("rts_n", rts_n, 1);
        chk("dtr_n", dtr_n, 1);
        chk("divisor", divisor, 32'h0001);
        apb(0, 3'h2, 8'h00);
        chk("ident", rd, 32'h01);
        apb(0, 3'h3, 8'h00);
        chk("line_format", rd, 32'h00);
        $display("reset test done");
        // Line format rows: parity, length, stop and break
        foreach (rows[i]) begin
            apb(1, 3'h3, rows[i].fmt);
            #1;
            chk("parity", parity_mode, rows[i].par);
            chk("length", char_length_sel, rows[i].len);
            chk("stop", extra_stop_sel, rows[i].stop);
            chk("sout", sout_pin, !rows[i].fmt[6]);
            apb(0, 3'h3, 8'h00);
            chk("line_format rb", rd, rows[i].fmt);
        end
        apb(1, 3'h3, 8'h00);
        $display("line format test done");
        // Each enable alone picks its own source, gate open
        apb(1, 3'h4, 8'h08);
        src_v <= 5'h0F;
        for (int i = 0; i < 4; i++) begin
            apb(1, 3'h1, 8'h01 << i);
            #1;
            chk("irq", irq, 1);
            apb(0, 3'h2, 8'h00);
            chk("ident", rd, {28'h0, codes[i], 1'b0});
        end
        apb(1, 3'h1, 8'h00);
        #1;
        chk("irq off", irq, 0);
        apb(1, 3'h1, 8'h0F);
        apb(0, 3'h2, 8'h00);
        chk("ident line", rd, 32'h06);
        src_v <= 5'h10;
        apb(1, 3'h1, 8'h01);
        apb(0, 3'h2, 8'h00);
        chk("ident timeout", rd, 32'h0C);
        apb(1, 3'h4, 8'h00);
        #1;
        chk("irq gated", irq, 0);
        src_v <= 5'h00;
        $display("interrupt test done");
        // Divisor window hides data and enables
        apb(1, 3'h1, 8'h05);
        apb(1, 3'h3, 8'h80);
        apb(1, 3'h0, 8'h34);
        apb(1, 3'h1, 8'h12);
        #1;
        chk("divisor", divisor, 32'h1234);
        chk("tx writes", n_wr, 0);
        apb(0, 3'h1, 8'h00);
        chk("divisor hi", rd, 32'h12);
        apb(1, 3'h3, 8'h00);
        apb(0, 3'h1, 8'h00);
        chk("enables kept", rd, 32'h05);
        apb(1, 3'h0, 8'h5A);
        repeat (2) @(posedge clk);
        #1;
        chk("tx data", tx_data, 32'h5A);
        chk("tx writes", n_wr, 1);
        $display("divisor test done");
        // Address-only receive follows nine-bit mode
        apb(1, 3'h1, 8'h11);
        apb(0, 3'h1, 8'h00);
        chk("enable rb", rd, 32'h01);
        chk("addr only", address_only_receive, 0);
        nine_bit_mode <= 1'b1;
        apb(0, 3'h1, 8'h00);
        chk("enable rb", rd, 32'h11);
        chk("addr only", address_only_receive, 1);
        apb(1, 3'h4, 8'h08);
        addr_rcvd <= 1'b1;
        @(posedge clk);
        addr_rcvd <= 1'b0;
        #1;
        chk("addr irq", irq, 1);
        apb(0, 3'h2, 8'h00);
        chk("ident addr", rd, 32'h04);
        apb(0, 3'h0, 8'h00);
        chk("rx byte", rd, 32'hA5);
        repeat (2) @(posedge clk);
        #1;
        chk("rx reads", n_rd, 1);
        chk("addr irq clr", irq, 0);
        apb(1, 3'h4, 8'h00);
        nine_bit_mode <= 1'b0;
        apb(1, 3'h1, 8'h00);
        $display("address test done");
        // Modem control, then internal loopback
        slow <= 1'b1;
        apb(1, 3'h4, 8'h03);
        #1;
        chk("rts_n", rts_n, 0);
        chk("dtr_n", dtr_n, 0);
        wait_lines(4'hB);
        apb(1, 3'h4, 8'h1F);
        wait_lines(4'hF);
        tx_ser <= 1'b0;
        #1;
        chk("loop rx", rx_serial, 0);
        chk("loop sout", sout_pin, 1);
        apb(1, 3'h4, 8'h14);
        wait_lines(4'h4);
        apb(1, 3'h4, 8'h00);
        tx_ser <= 1'b1;
        $display("modem test done");
        // Trigger levels and flush strobes, ident shows FIFO state
        for (int t = 0; t < 4; t++) begin
            apb(1, 3'h2, {t[1:0], 6'h07});
            repeat (2) @(posedge clk);
            #1;
            chk("threshold", rx_threshold, thr[t]);
            chk("fifo on", fifo_enable, 1);
            chk("tx flush", n_txf, t + 1);
            chk("rx flush", n_rxf, t + 1);
        end
        apb(0, 3'h2, 8'h00);
        chk("ident fifo", rd, 32'hC1);
        apb(1, 3'h2, 8'h00);
        apb(0, 3'h5, 8'h00);
        chk("unmapped err", err, 1);
        chk("unmapped rd", rd, 0);
        $display("fifo test done");
        close_out();
    end

    // Whole run is near 210 cycles; this limit catches a hang
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        close_out();
    end
endmodule : testbench
